//--- rtl/led_scan_pkg.sv
package led_scan_pkg;
   // register address codes; bit 7 of the address marks a read
   localparam logic [6:0] ADDR_NOOP = 7'h00;
   localparam logic [6:0] ADDR_BRIGHT_LOW = 7'h01;
   localparam logic [6:0] ADDR_BRIGHT_HIGH = 7'h02;
   localparam logic [6:0] ADDR_SCAN_LIMIT = 7'h03;
   localparam logic [6:0] ADDR_GLYPH = 7'h05;
   localparam int ADDR_READ_BIT = 7;

   // register reset values
   localparam logic [7:0] BRIGHT_RESET = 8'h00;
   localparam logic [7:0] SCAN_LIMIT_RESET = 8'h00;
   localparam int SCAN_LIMIT_BIT = 0;
   localparam int NIBBLE_W = 4;

   // user glyph store
   localparam logic [7:0] GLYPH_PTR_FIRST = 8'h80;
   localparam logic [7:0] GLYPH_PTR_LAST = 8'hf7;
   localparam int GLYPH_LOAD_BIT = 7;
   localparam int GLYPH_ENTRIES = 120;
   localparam int GLYPH_COUNT = 24;
   localparam logic [7:0] GLYPH_COLS = 8'h05;
   localparam int GLYPH_W = 7;

   // multiplex timing, in multiplex clock periods at the reference rate
   localparam int MUX_REF_MHZ = 4;
   localparam int SCAN_RATIO = 5600;
   localparam int SLOT_TIME_US = 100;
   localparam int SLOT_MUX_CYCLES = SLOT_TIME_US * MUX_REF_MHZ;
   localparam int SLOTS_PER_SCAN = SCAN_RATIO / SLOT_MUX_CYCLES;
   localparam int PWM_STEPS = 16;
   localparam logic [3:0] PWM_LAST_STEP = 4'hf;

   // blink: 0.5 Hz slow and 1 Hz fast, each plane shown for half a period
   localparam int BLINK_SLOW_HALF_MS = 1000;
   localparam int BLINK_FAST_HALF_MS = 500;
   localparam int BLINK_SLOW_HALF_SLOTS = BLINK_SLOW_HALF_MS * 1000 / SLOT_TIME_US;
   localparam int BLINK_FAST_HALF_SLOTS = BLINK_FAST_HALF_MS * 1000 / SLOT_TIME_US;

   // external multiplex clock limits
   localparam int MUX_MAX_MHZ = 8;
   localparam int CLK_MHZ = 50;

   typedef enum logic {
      PAIR_LOW = 1'b0,
      PAIR_HIGH = 1'b1
   } scan_pair_t;
endpackage : led_scan_pkg

//--- rtl/digit_pwm.sv
`timescale 1ns/1ns
// one duty modulator for one digit; the last step of a slot is always dark
module digit_pwm (
   input wire logic [3:0] step,
   input wire logic [3:0] level,
   input wire logic selected,
   output logic on
);
   // level n lights steps 0..n, capped so step 15 stays blanked
   always_comb begin
      on = selected && (step <= level) && (step != led_scan_pkg::PWM_LAST_STEP); // [R19]
   end
endmodule : digit_pwm

//--- rtl/led_matrix_scan_blink_font_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// [R01] scan period is the multiplex clock divided by 5600
// [R02] each digit slot lasts 100 us at a 4 MHz multiplex clock
// [R03] host supplies 1 to 8 MHz external clock when exact blink is needed
// [R04] host writes blink-sync to all drivers quickly to align their phases
// [R05] cascaded drivers get their control register in one transfer
// [R06] blink output is high in first-plane phase, low in second-plane phase
// [R07] current blink phase is readable as a status bit
// [R08] glyph read at 0x85 returns 7 bits, top bit clear, then advances pointer
// [R09] glyph write of 0x00-0x7f stores data at pointer then advances
// [R10] glyph write of 0x80-0xff loads the pointer instead
// [R11] pointer in 0x80-0xf6 steps by one after each glyph access
// [R12] glyph access at pointer 0xf7 wraps pointer to 0x80
// [R13] pointer load of 0xf8-0xff sets the pointer to 0x80
// [R14] 24 glyphs of five columns from 0x80; glyph n at 0x80 plus 5n
// [R15] digits zero and one share a slot, then digits two and three
// [R16] one scan-limit bit: clear scans first pair, set scans both pairs
// [R17] host changes scan limit only while in shutdown
// [R18] four digit modulators, each from one nibble of a pair brightness register
// [R19] sixteen duty settings 1/16 to 15/16, at least 1/16 blanked
// [R20] writes to the no-operation register are discarded
// [R21] blink is 0.5 Hz slow and 1 Hz fast at 4 MHz multiplex clock
// [R22] blink-sync written as one resets blink counters at chip-select rise
// [R23] phase readback bit reads one in first-plane, zero in second-plane phase
// [R24] with blink on, first plane shows first half, second plane second half
// [R25] blink counter runs from scan slots so transitions meet slot edges
module led_matrix_scan_blink_font_ctrl #(
   parameter int SLOT_CYCLES = led_scan_pkg::SLOT_MUX_CYCLES,
   parameter int SLOW_HALF_SLOTS = led_scan_pkg::BLINK_SLOW_HALF_SLOTS,
   parameter int FAST_HALF_SLOTS = led_scan_pkg::BLINK_FAST_HALF_SLOTS,
   parameter int SCAN_SLOTS = led_scan_pkg::SLOTS_PER_SCAN
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic mux_clock_pin,
   input wire logic reg_strobe,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic ctrl_wr,
   input wire logic ctrl_sync_bit,
   input wire logic cs_rise,
   input wire logic blink_enable,
   input wire logic blink_fast,
   input wire logic shutdown,
   input wire logic [4:0] glyph_sel,
   input wire logic [2:0] glyph_col,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic [3:0] digit_on,
   output logic pair_high,
   output logic blink_out,
   output logic phase_status,
   output logic show_first_plane,
   output logic [6:0] glyph_col_data
);
   localparam int STEP_LEN = SLOT_CYCLES / led_scan_pkg::PWM_STEPS;
   localparam int SUB_W = $clog2(STEP_LEN + 1);
   localparam int SLOT_W = $clog2(SCAN_SLOTS + 1);
   localparam int BLINK_W = $clog2(SLOW_HALF_SLOTS + 1);
   localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(STEP_LEN - 1);
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SCAN_SLOTS - 1);
   localparam logic [BLINK_W-1:0] SLOW_LAST = BLINK_W'(SLOW_HALF_SLOTS - 1);
   localparam logic [BLINK_W-1:0] FAST_LAST = BLINK_W'(FAST_HALF_SLOTS - 1);

   // refuse settings the counters cannot serve
   generate
      if (STEP_LEN < 1 || SLOT_CYCLES % led_scan_pkg::PWM_STEPS != 0) begin : g_bad_slot
         $error("slot length must be a nonzero multiple of the duty steps");
      end
      if (FAST_HALF_SLOTS < 1 || FAST_HALF_SLOTS > SLOW_HALF_SLOTS) begin : g_bad_blink
         $error("blink half periods must satisfy 1 <= fast <= slow");
      end
      if (SCAN_SLOTS < 2) begin : g_bad_scan
         $error("a scan needs at least two slots");
      end
      if (led_scan_pkg::CLK_MHZ < 4 * led_scan_pkg::MUX_MAX_MHZ) begin : g_bad_clk
         $error("system clock too slow to sample the multiplex clock");
      end
   endgenerate

   // register store and pointer
   logic [7:0] bright_low_ff, bright_high_ff;
   logic [7:0] scan_limit_ff;
   logic [7:0] glyph_ptr_ff;
   logic [7:0] nxt_glyph_ptr;
   localparam int GLYPH_W_L = led_scan_pkg::GLYPH_W;
   logic [GLYPH_W_L-1:0] glyph_mem [0:led_scan_pkg::GLYPH_ENTRIES-1];
   logic [7:0] reg_rdata_ff;
   logic reg_rvalid_ff;

   // multiplex clock synchroniser and tick
   logic mux_s1_ff, mux_s2_ff, mux_s3_ff, mux_level_ff;
   logic mux_tick;

   // scan and blink state
   logic [SUB_W-1:0] sub_cnt_ff;
   logic [3:0] step_ff;
   logic [SLOT_W-1:0] slot_cnt_ff;
   led_scan_pkg::scan_pair_t pair_ff;
   led_scan_pkg::scan_pair_t nxt_pair;
   logic slot_end;
   logic [BLINK_W-1:0] blink_cnt_ff;
   logic blink_phase_ff;
   logic sync_pending_ff;
   logic sync_fire;

   logic [3:0] pwm_on;
   logic [3:0] digit_on_ff;
   logic pair_high_ff;
   logic blink_out_ff;
   logic phase_status_ff;
   logic show_first_ff;
   logic [6:0] glyph_col_ff;

   logic is_read;
   logic is_write;
   logic [6:0] reg_code;
   logic glyph_touch;

   // pointer step: wraps to the first entry after the last one
   function automatic logic [7:0] ptr_step(input logic [7:0] p);
      if (p >= led_scan_pkg::GLYPH_PTR_LAST || p < led_scan_pkg::GLYPH_PTR_FIRST) begin
         return led_scan_pkg::GLYPH_PTR_FIRST; // [R12]
      end
      return 8'(p + 8'h01); // [R11]
   endfunction : ptr_step

   // pointer load: out-of-range values fall back to the first entry
   function automatic logic [7:0] ptr_load(input logic [7:0] v);
      if (v > led_scan_pkg::GLYPH_PTR_LAST) begin
         return led_scan_pkg::GLYPH_PTR_FIRST; // [R13]
      end
      return v;
   endfunction : ptr_load

   // memory index of a pointer value
   function automatic logic [6:0] ptr_index(input logic [7:0] p);
      return 7'(p - led_scan_pkg::GLYPH_PTR_FIRST);
   endfunction : ptr_index

   // first pointer value of glyph n, five columns per glyph
   function automatic logic [7:0] glyph_base(input logic [4:0] n);
      return 8'(led_scan_pkg::GLYPH_PTR_FIRST + 8'(n) * led_scan_pkg::GLYPH_COLS); // [R14]
   endfunction : glyph_base

   assign reg_code = reg_addr[6:0];
   assign is_read = reg_strobe && reg_addr[led_scan_pkg::ADDR_READ_BIT];
   assign is_write = reg_strobe && !reg_addr[led_scan_pkg::ADDR_READ_BIT];
   // a glyph data access, read or write, moves the pointer on
   assign glyph_touch = reg_strobe && (reg_code == led_scan_pkg::ADDR_GLYPH) &&
                        (is_read || !reg_wdata[led_scan_pkg::GLYPH_LOAD_BIT]);

   // pointer update; load and step never collide since load is a write with msb set
   always_comb begin
      nxt_glyph_ptr = glyph_ptr_ff;
      if (is_write && reg_code == led_scan_pkg::ADDR_GLYPH &&
          reg_wdata[led_scan_pkg::GLYPH_LOAD_BIT]) begin
         nxt_glyph_ptr = ptr_load(reg_wdata); // [R10]
      end else if (glyph_touch) begin
         nxt_glyph_ptr = ptr_step(glyph_ptr_ff); // [R08] [R09]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         glyph_ptr_ff <= led_scan_pkg::GLYPH_PTR_FIRST;
      end else begin
         glyph_ptr_ff <= nxt_glyph_ptr;
      end
   end

   // glyph store; data only, so it carries no reset
   always_ff @(posedge clk) begin
      if (is_write && reg_code == led_scan_pkg::ADDR_GLYPH &&
          !reg_wdata[led_scan_pkg::GLYPH_LOAD_BIT]) begin
         glyph_mem[ptr_index(glyph_ptr_ff)] <= reg_wdata[6:0]; // [R09]
      end
   end

   // configuration writes; the ignored_write_slot code and unknown codes change nothing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bright_low_ff <= led_scan_pkg::BRIGHT_RESET;
         bright_high_ff <= led_scan_pkg::BRIGHT_RESET;
         scan_limit_ff <= led_scan_pkg::SCAN_LIMIT_RESET;
      end else if (is_write) begin
         case (reg_code)
            led_scan_pkg::ADDR_NOOP: begin
               scan_limit_ff <= scan_limit_ff; // [R20]
            end
            led_scan_pkg::ADDR_BRIGHT_LOW: begin
               bright_low_ff <= reg_wdata; // [R18]
            end
            led_scan_pkg::ADDR_BRIGHT_HIGH: begin
               bright_high_ff <= reg_wdata; // [R18]
            end
            led_scan_pkg::ADDR_SCAN_LIMIT: begin
               scan_limit_ff <= reg_wdata; // [R16] [R17]
            end
            default: begin
               scan_limit_ff <= scan_limit_ff;
            end
         endcase
      end
   end

   // read answer one cycle after the strobe; glyph data has its top bit clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata_ff <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= is_read;
         if (is_read) begin
            case (reg_code)
               led_scan_pkg::ADDR_GLYPH: begin
                  reg_rdata_ff <= {1'b0, glyph_mem[ptr_index(glyph_ptr_ff)]}; // [R08]
               end
               led_scan_pkg::ADDR_BRIGHT_LOW: begin
                  reg_rdata_ff <= bright_low_ff;
               end
               led_scan_pkg::ADDR_BRIGHT_HIGH: begin
                  reg_rdata_ff <= bright_high_ff;
               end
               led_scan_pkg::ADDR_SCAN_LIMIT: begin
                  reg_rdata_ff <= scan_limit_ff;
               end
               default: begin
                  reg_rdata_ff <= 8'h00;
               end
            endcase
         end
      end
   end

   // column lookup for the character generator, out-of-range picks read dark
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         glyph_col_ff <= 7'h00;
      end else if (32'(glyph_sel) < led_scan_pkg::GLYPH_COUNT &&
                   8'(glyph_col) < led_scan_pkg::GLYPH_COLS) begin
         glyph_col_ff <= glyph_mem[ptr_index(8'(glyph_base(glyph_sel) + 8'(glyph_col)))]; // [R14]
      end else begin
         glyph_col_ff <= 7'h00;
      end
   end

   // the pin clock is asynchronous; a rising edge counts once stages two and three agree
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mux_s1_ff <= 1'b0;
         mux_s2_ff <= 1'b0;
         mux_s3_ff <= 1'b0;
         mux_level_ff <= 1'b0;
      end else begin
         mux_s1_ff <= mux_clock_pin; // [R03]
         mux_s2_ff <= mux_s1_ff;
         mux_s3_ff <= mux_s2_ff;
         if (mux_s2_ff == mux_s3_ff) begin
            mux_level_ff <= mux_s3_ff;
         end
      end
   end

   assign mux_tick = (mux_s2_ff == mux_s3_ff) && mux_s3_ff && !mux_level_ff;
   assign slot_end = mux_tick && (sub_cnt_ff == SUB_LAST) &&
                     (step_ff == led_scan_pkg::PWM_LAST_STEP);

   // duty step counter inside a slot: sixteen steps make one slot
   // a sync restarts the slot too, else synced drivers could differ by up to a slot
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sub_cnt_ff <= '0;
         step_ff <= 4'h0;
      end else if (sync_fire) begin
         {sub_cnt_ff, step_ff} <= '0; // [R22]
      end else if (mux_tick) begin
         if (sub_cnt_ff == SUB_LAST) begin
            sub_cnt_ff <= '0;
            step_ff <= 4'(step_ff + 4'h1); // [R02]
         end else begin
            sub_cnt_ff <= SUB_W'(sub_cnt_ff + 1'b1);
         end
      end
   end

   // slot counter: fourteen slots of 400 make the scan ratio of 5600
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slot_cnt_ff <= '0;
      end else if (slot_end) begin
         slot_cnt_ff <= (slot_cnt_ff == SLOT_LAST) ? '0 : SLOT_W'(slot_cnt_ff + 1'b1); // [R01]
      end
   end

   // pair sequencer; limit bit clear keeps the low pair in every slot
   always_comb begin
      case (pair_ff)
         led_scan_pkg::PAIR_LOW: begin
            nxt_pair = scan_limit_ff[led_scan_pkg::SCAN_LIMIT_BIT] ?
                       led_scan_pkg::PAIR_HIGH : led_scan_pkg::PAIR_LOW; // [R15] [R16]
         end
         led_scan_pkg::PAIR_HIGH: begin
            nxt_pair = led_scan_pkg::PAIR_LOW; // [R15]
         end
         default: begin
            nxt_pair = led_scan_pkg::PAIR_LOW;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pair_ff <= led_scan_pkg::PAIR_LOW;
      end else if (slot_end) begin
         pair_ff <= nxt_pair;
      end
   end

   // sync request waits for chip select to rise; a new request beats the clear
   assign sync_fire = cs_rise && (sync_pending_ff || (ctrl_wr && ctrl_sync_bit));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_pending_ff <= 1'b0;
      end else if (ctrl_wr) begin
         sync_pending_ff <= ctrl_sync_bit && !cs_rise; // [R22] [R04] [R05]
      end else if (cs_rise) begin
         sync_pending_ff <= 1'b0;
      end
   end

   // blink counts whole slots, so a phase change always lands on a slot edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blink_cnt_ff <= '0;
         blink_phase_ff <= 1'b1;
      end else if (sync_fire) begin
         blink_cnt_ff <= '0; // [R22]
         blink_phase_ff <= 1'b1;
      end else if (slot_end) begin
         if (blink_cnt_ff >= (blink_fast ? FAST_LAST : SLOW_LAST)) begin
            blink_cnt_ff <= '0; // [R21] [R25]
            blink_phase_ff <= !blink_phase_ff;
         end else begin
            blink_cnt_ff <= BLINK_W'(blink_cnt_ff + 1'b1);
         end
      end
   end

   // four modulators; even digits use the low nibble of their pair register
   for (genvar d = 0; d < 4; d++) begin : g_digit
      logic [7:0] pair_reg;
      assign pair_reg = (d < 2) ? bright_low_ff : bright_high_ff;
      digit_pwm u_pwm (
         .step(step_ff),
         .level(pair_reg[(d % 2) * led_scan_pkg::NIBBLE_W +: led_scan_pkg::NIBBLE_W]), // [R18]
         .selected((d < 2) ? (pair_ff == led_scan_pkg::PAIR_LOW) :
                             (pair_ff == led_scan_pkg::PAIR_HIGH)), // [R15]
         .on(pwm_on[d])
      );
   end

   // output flops; shutdown blanks the digits but scan and blink keep running
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         digit_on_ff <= 4'h0;
         pair_high_ff <= 1'b0;
      end else begin
         digit_on_ff <= shutdown ? 4'h0 : pwm_on; // [R19]
         pair_high_ff <= (pair_ff == led_scan_pkg::PAIR_HIGH);
      end
   end

   // phase outputs; plane choice falls back to the first plane with blink off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blink_out_ff <= 1'b1;
         phase_status_ff <= 1'b1;
         show_first_ff <= 1'b1;
      end else begin
         blink_out_ff <= blink_phase_ff; // [R06]
         phase_status_ff <= blink_phase_ff; // [R07] [R23]
         show_first_ff <= !blink_enable || blink_phase_ff; // [R24]
      end
   end

   assign reg_rdata = reg_rdata_ff;
   assign reg_rvalid = reg_rvalid_ff;
   assign digit_on = digit_on_ff;
   assign pair_high = pair_high_ff;
   assign blink_out = blink_out_ff;
   assign phase_status = phase_status_ff;
   assign show_first_plane = show_first_ff;
   assign glyph_col_data = glyph_col_ff;
endmodule : led_matrix_scan_blink_font_ctrl

//--- tb/led_scan_checker.sv
`timescale 1ns/1ns
// port-level relations of the scan, blink and glyph register logic
module led_scan_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_strobe,
   input wire logic [7:0] reg_addr,
   input wire logic ctrl_wr,
   input wire logic ctrl_sync_bit,
   input wire logic cs_rise,
   input wire logic blink_enable,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [3:0] digit_on,
   input wire logic pair_high,
   input wire logic blink_out,
   input wire logic phase_status,
   input wire logic show_first_plane
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // a write never produces an answer, so a stray rvalid means a decode slip
   read_answer_a: assert property (reg_strobe && reg_addr[7] |=> reg_rvalid)
      else $error("read request got no answer");
   write_silent_a: assert property (!(reg_strobe && reg_addr[7]) |=> !reg_rvalid)
      else $error("answer without a read request");
   glyph_msb_a: assert property (reg_strobe && reg_addr == 8'h85 |=> !reg_rdata[7])
      else $error("glyph read top bit set");
   noop_read_a: assert property (reg_strobe && reg_addr == 8'h80 |=> reg_rdata == 8'h00)
      else $error("ignored_write_slot place read nonzero");
   phase_mirror_a: assert property (phase_status == blink_out)
      else $error("phase status differs from blink output");
   plane_idle_a: assert property (!blink_enable [*2] |-> show_first_plane)
      else $error("second plane shown with blink off");
   plane_blink_a: assert property ((blink_enable && $stable(blink_out)) [*3]
      |-> show_first_plane == blink_out) else $error("plane select not following phase");
   pair_low_a: assert property (|digit_on[1:0] |-> !pair_high)
      else $error("low digits driven in high slot");
   pair_high_a: assert property (|digit_on[3:2] |-> pair_high)
      else $error("high digits driven in low slot");
   sync_phase_a: assert property (ctrl_wr && ctrl_sync_bit && cs_rise
      |-> ##[1:2] (blink_out && phase_status)) else $error("sync did not restart phase");
   phase_hold_a: assert property ($changed(blink_out) |=> $stable(blink_out) [*8])
      else $error("blink phase flickered");
endmodule : led_scan_checker

bind led_matrix_scan_blink_font_ctrl led_scan_checker led_scan_checker_i (.clk, .sys_rst,
   .reg_strobe, .reg_addr, .ctrl_wr, .ctrl_sync_bit, .cs_rise, .blink_enable, .reg_rdata,
   .reg_rvalid, .digit_on, .pair_high, .blink_out, .phase_status, .show_first_plane);

//--- tb/host_model.sv
`timescale 1ns/1ns
// host side: external multiplex clock plus register and control strobes
module host_model (
   input wire logic clk,
   input wire logic reg_rvalid,
   input wire logic [7:0] reg_rdata,
   output logic mux_clock_pin,
   output logic reg_strobe,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic ctrl_wr,
   output logic ctrl_sync_bit,
   output logic cs_rise
);
   // 4 mhz, offset so no edge meets a clk edge
   initial begin
      mux_clock_pin = 1'b0;
      reg_strobe = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      ctrl_wr = 1'b0;
      ctrl_sync_bit = 1'b0;
      cs_rise = 1'b0;
      #7;
      forever #125 mux_clock_pin = ~mux_clock_pin;
   end

   // one-cycle strobe; a read waits a bounded time for its answer
   task access(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
      rd = 8'hxx;
      @(posedge clk);
      reg_strobe <= 1'b1;
      reg_addr <= addr;
      reg_wdata <= data;
      @(posedge clk);
      reg_strobe <= 1'b0;
      if (addr[7]) begin
         repeat (4) begin
            #1;
            if (reg_rvalid === 1'b1) begin
               rd = reg_rdata;
               break;
            end
            @(posedge clk);
         end
      end
   endtask : access

   // control write and chip-select rise in one transfer
   task sync(input logic bit_v);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_sync_bit <= bit_v;
      cs_rise <= 1'b1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      cs_rise <= 1'b0;
   endtask : sync
endmodule : host_model

//--- tb/led_matrix_scan_blink_font_ctrl_tb_top.sv
`timescale 1ns/1ns
module led_matrix_scan_blink_font_ctrl_tb_top;
   localparam int SLOT = 32;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic blink_enable = 1'b0;
   logic blink_fast = 1'b0;
   logic shutdown = 1'b1;
   logic [4:0] glyph_sel = 5'h00;
   logic [2:0] glyph_col = 3'h0;
   logic mux_clock_pin, reg_strobe, ctrl_wr, ctrl_sync_bit, cs_rise, reg_rvalid;
   logic pair_high, blink_out, phase_status, show_first_plane;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, v;
   logic [3:0] digit_on;
   logic [6:0] glyph_col_data;
   logic [6:0] exp_mem [120];
   logic [15:0] br;
   logic [31:0] seed = 32'h00000010;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   int on_cnt [4];
   int n, t, half;

   always #10 clk = ~clk;

   led_matrix_scan_blink_font_ctrl #(.SLOT_CYCLES(SLOT), .SLOW_HALF_SLOTS(4),
      .FAST_HALF_SLOTS(2), .SCAN_SLOTS(2)) led_matrix_scan_blink_font_ctrl_i (.clk(clk),
      .sys_rst(sys_rst), .mux_clock_pin(mux_clock_pin), .reg_strobe(reg_strobe),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ctrl_wr(ctrl_wr),
      .ctrl_sync_bit(ctrl_sync_bit), .cs_rise(cs_rise), .blink_enable(blink_enable),
      .blink_fast(blink_fast), .shutdown(shutdown), .glyph_sel(glyph_sel),
      .glyph_col(glyph_col), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .digit_on(digit_on), .pair_high(pair_high), .blink_out(blink_out),
      .phase_status(phase_status), .show_first_plane(show_first_plane),
      .glyph_col_data(glyph_col_data));

   host_model host_model_i (.clk(clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
      .mux_clock_pin(mux_clock_pin), .reg_strobe(reg_strobe), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .ctrl_wr(ctrl_wr), .ctrl_sync_bit(ctrl_sync_bit),
      .cs_rise(cs_rise));

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand

   // clk cycles a digit is lit in a 1600-cycle window (four slots of 12.5-cycle ticks)
   function automatic int exp_on(input int lvl, input bit lim, input bit hi);
      int steps;
      steps = (lvl + 1 > 15) ? 15 : lvl + 1;
      if (hi && !lim) return 0;
      return steps * ((lim || hi) ? 50 : 100);
   endfunction : exp_on

   task check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check8

   // tick jitter through the synchroniser allows a small slack
   task check_near(input int got, input int exp, input string what);
      samples_checked++;
      if (got < exp - 40 || got > exp + 40) begin
         failures++;
         $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : check_near

   task time_to(input logic lvl, output int cnt);
      cnt = 0;
      while (blink_out !== lvl && cnt < 4000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : time_to

   task end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   // a hang is cut off well beyond the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 50000) begin
         failures++;
         $display("BAD %0t run did not finish", $time);
         end_of_test();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a <= 4; a++) begin
         host_model_i.access(8'h80 | 8'(a), 8'h00, rd);
         check8(rd, 8'h00, "reset value");
      end
      for (int i = 0; i < 6; i++) begin
         v = 8'(next_rand());
         host_model_i.access(8'(1 + i % 3), v, rd);
         host_model_i.access(8'h00, 8'(next_rand()), rd);
         host_model_i.access(8'(8'h81 + i % 3), 8'h00, rd);
         check8(rd, v, "register readback");
      end
      host_model_i.access(8'h84, 8'h00, rd);
      check8(rd, 8'h00, "unmapped read");
      $display("registers done");
      // fill all entries; the pointer must wrap home after the last one
      host_model_i.access(8'h05, 8'h80, rd);
      for (int i = 0; i < 120; i++) begin
         exp_mem[i] = 7'(next_rand());
         host_model_i.access(8'h05, {1'b0, exp_mem[i]}, rd);
      end
      host_model_i.access(8'h85, 8'h00, rd);
      check8(rd, {1'b0, exp_mem[0]}, "wrap after fill");
      host_model_i.access(8'h05, 8'h8a, rd);
      for (int i = 0; i < 5; i++) begin
         host_model_i.access(8'h85, 8'h00, rd);
         check8(rd, {1'b0, exp_mem[10 + i]}, "glyph read");
      end
      host_model_i.access(8'h05, 8'hfb, rd);
      host_model_i.access(8'h85, 8'h00, rd);
      check8(rd, {1'b0, exp_mem[0]}, "out of range load");
      host_model_i.access(8'h05, 8'hf7, rd);
      host_model_i.access(8'h85, 8'h00, rd);
      check8(rd, {1'b0, exp_mem[119]}, "last entry");
      host_model_i.access(8'h85, 8'h00, rd);
      check8(rd, {1'b0, exp_mem[0]}, "wrap after read");
      for (int i = 0; i < 8; i++) begin
         n = (i == 0) ? 23 : int'(next_rand() % 26);
         t = (i == 0) ? 4 : int'(next_rand() % 6);
         glyph_sel <= 5'(n);
         glyph_col <= 3'(t);
         repeat (3) @(posedge clk);
         #1;
         v = (n < 24 && t < 5) ? {1'b0, exp_mem[n * 5 + t]} : 8'h00;
         check8({1'b0, glyph_col_data}, v, "glyph lookup");
      end
      $display("glyph store done");
      // corner levels first and last, random ones between, under both scan limits
      for (int k = 0; k < 4; k++) begin
         br = (k == 0) ? 16'hf00f : (k == 3) ? 16'h0ff0 : 16'(next_rand());
         shutdown <= 1'b1;
         host_model_i.access(8'h03, {7'h00, k[0]}, rd);
         host_model_i.access(8'h01, br[7:0], rd);
         host_model_i.access(8'h02, br[15:8], rd);
         shutdown <= 1'b0;
         repeat (SLOT * 25) @(posedge clk);
         on_cnt = '{0, 0, 0, 0};
         repeat (1600) begin
            @(posedge clk);
            #1;
            for (int d = 0; d < 4; d++) on_cnt[d] += (digit_on[d] === 1'b1) ? 1 : 0;
         end
         for (int d = 0; d < 4; d++) begin
            check_near(on_cnt[d], exp_on(int'(br[d*4 +: 4]), k[0], d > 1), "duty");
         end
      end
      $display("scan done");
      blink_enable <= 1'b1;
      for (int f = 0; f < 2; f++) begin
         blink_fast <= f[0];
         half = (f == 1) ? 800 : 1600;
         host_model_i.sync(1'b1);
         repeat (300) @(posedge clk);
         host_model_i.sync(1'b0);
         time_to(1'b0, t);
         check_near(t + 302, half, "first plane time");
         time_to(1'b1, t);
         check_near(t, half, "second plane time");
      end
      $display("blink done");
      end_of_test();
   end
endmodule : led_matrix_scan_blink_font_ctrl_tb_top
